// file: core/otpwp_bus_cycle.sv
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`include "otpwp_consts.svh"
module otpwp_bus_cycle (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic start_in, // Begin a cycle, one pulse
    input wire logic write_in, // 1 write, 0 read
    input wire logic [23:0] addr_in, // Address of the cycle
    input wire logic [7:0] wdata_in, // Data to write
    input wire logic [7:0] dq_in, // Data pins as seen
    output logic [23:0] addr_out, // Address pins
    output logic [7:0] dq_out, // Data pins driven
    output logic dq_oe_n_out, // Data drive enable, low drives
    output logic chip_sel_out, // Chip select level, high selects
    output logic we_n_out, // Write strobe, active low
    output logic oe_n_out, // Output enable, active low
    output logic [7:0] rdata_out, // Captured read data
    output logic done_out // Cycle finished, one pulse
);
    logic [5:0] cnt_q, cnt_d;
    logic busy_q, busy_d, wr_q, wr_d, done_q, done_d, cs_q, cs_d, we_q, we_d, oe_q, oe_d;
    logic dqoe_q, dqoe_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] wd_q, wd_d, rd_q, rd_d;

    always_comb begin
        busy_d = busy_q;
        wr_d = wr_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        cs_d = cs_q;
        we_d = we_q;
        oe_d = oe_q;
        dqoe_d = dqoe_q;
        addr_d = addr_q;
        wd_d = wd_q;
        rd_d = rd_q;
        if (!busy_q && start_in) begin
            busy_d = 1'b1;
            wr_d = write_in;
            addr_d = addr_in;
            wd_d = wdata_in;
            cs_d = 1'b1;
            we_d = !write_in;
            oe_d = write_in;
            dqoe_d = !write_in;
            cnt_d = write_in ? 6'(`OTPWP_T_WE_CYC) : 6'(`OTPWP_T_RD_CYC);
        end else if (busy_q) begin
            if (cnt_q != 6'h00) begin
                cnt_d = cnt_q - 6'h01;
            end else begin
                // Deselect after each cycle so the next read refreshes status
                busy_d = 1'b0;
                done_d = 1'b1;
                cs_d = 1'b0;
                we_d = 1'b1;
                oe_d = 1'b1;
                dqoe_d = 1'b1;
                if (!wr_q) begin
                    rd_d = dq_in;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 6'h00;
            done_q <= 1'b0;
            cs_q <= 1'b0;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            dqoe_q <= 1'b1;
            addr_q <= 24'h000000;
            wd_q <= 8'h00;
            rd_q <= 8'h00;
        end else begin
            busy_q <= busy_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            cs_q <= cs_d;
            we_q <= we_d;
            oe_q <= oe_d;
            dqoe_q <= dqoe_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
        end
    end

    assign addr_out = addr_q;
    assign dq_out = wd_q;
    assign dq_oe_n_out = dqoe_q;
    assign chip_sel_out = cs_q;
    assign we_n_out = we_q;
    assign oe_n_out = oe_q;
    assign rdata_out = rd_q;
    assign done_out = done_q;
endmodule : otpwp_bus_cycle

// file: core/otpwp_consts.svh
// Constants for the protection register program controller
`ifndef OTPWP_CONSTS_SVH
`define OTPWP_CONSTS_SVH

`define OTPWP_REG_CTRL 4'h0
`define OTPWP_REG_ADDR 4'h1
`define OTPWP_REG_DATA 4'h2
`define OTPWP_REG_STAT 4'h3
`define OTPWP_REG_RDAT 4'h4

`define OTPWP_CTRL_GO 0
`define OTPWP_CTRL_CLR 1
`define OTPWP_CTRL_RDARR 2
`define OTPWP_CTRL_RST 3

`define OTPWP_ST_BUSY 0
`define OTPWP_ST_DONE 1
`define OTPWP_ST_LOWSUP 2
`define OTPWP_ST_PROGFAIL 3
`define OTPWP_ST_LOCKED 4
`define OTPWP_ST_REFUSED 5
`define OTPWP_ST_TIMEOUT 6
`define OTPWP_ST_ABORT 7

`define OTPWP_SR_READY 7
`define OTPWP_SR_PROG 4
`define OTPWP_SR_SUPPLY 3
`define OTPWP_SR_PROTECT 1

`define OTPWP_CMD_SETUP 8'hC0
`define OTPWP_CMD_RDARR 8'hFF
`define OTPWP_CMD_CLRSR 8'h50
`define OTPWP_CMD_RDSR 8'h70

// Bus timing in ns and derived 200 MHz cycles (least times round up)
`define OTPWP_CLK_NS 5
`define OTPWP_T_WE_NS 70
`define OTPWP_T_WE_CYC ((`OTPWP_T_WE_NS + `OTPWP_CLK_NS - 1) / `OTPWP_CLK_NS)
`define OTPWP_T_RD_NS 150
`define OTPWP_T_RD_CYC ((`OTPWP_T_RD_NS + `OTPWP_CLK_NS - 1) / `OTPWP_CLK_NS)
`define OTPWP_T_RST_NS 35000
`define OTPWP_T_RST_CYC ((`OTPWP_T_RST_NS + `OTPWP_CLK_NS - 1) / `OTPWP_CLK_NS)
`define OTPWP_POLL_MAX 20000

`endif

// file: core/otpwp_ctrl.sv
// Host controller that programs the flash protection register
// Behaviour
// - Write setup code, then data at location.
// - Supply error blocks retries until cleared.
// - Finish with read-array command.
// - Reissue aborted operation after reset completes (here reset sets the abort status bit, clears the supply hold and goes idle).
// - Read-array before accessing memory contents.
// - Writes need strobe low and device selected.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "otpwp_consts.svh"
module otpwp_ctrl
    import otpwp_pkg::*;
#(
    parameter int unsigned RST_CYC = `OTPWP_T_RST_CYC // Reset pulse plus recovery
) (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic [3:0] reg_addr_in, // Register address
    input wire logic [31:0] reg_wdata_in, // Register write data
    input wire logic reg_wr_in, // Register write strobe
    input wire logic reg_rd_in, // Register read strobe
    output logic [31:0] reg_rdata_out, // Register read data, next cycle
    output logic [23:0] flash_addr_out, // Flash address pins
    output logic [7:0] flash_dq_out, // Flash data driven
    output logic flash_dq_oe_n_out, // Flash data drive enable, low drives
    input wire logic [7:0] flash_dq_in, // Flash data seen
    output logic chip_select_inputs_out, // Flash select level, high selects
    output logic flash_we_n_out, // Flash write strobe
    output logic flash_oe_n_out, // Flash output enable
    output logic reset_powerdown_low_n_out, // Flash reset/power-down, active low
    input wire logic completion_output_in, // Completion pin level, low busy
    output logic busy_out // Controller busy level
);
    otpwp_state_t st_q, st_d, ret_q, ret_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] data_q, data_d, sr_q, sr_d;
    logic [7:0] stat_q, stat_d;
    logic [31:0] rdata_q, rdata_d;
    logic rp_q, rp_d, busy_q, busy_d, supply_hold_q, supply_hold_d;
    logic [15:0] tmr_q, tmr_d;
    logic cyc_start, cyc_write;
    logic [23:0] cyc_addr;
    logic [7:0] cyc_wdata, cyc_rdata;
    logic cyc_done, cyc_pend_q, cyc_pend_d;

    otpwp_bus_cycle u_cycle (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .start_in(cyc_start),
        .write_in(cyc_write),
        .addr_in(cyc_addr),
        .wdata_in(cyc_wdata),
        .dq_in(flash_dq_in),
        .addr_out(flash_addr_out),
        .dq_out(flash_dq_out),
        .dq_oe_n_out(flash_dq_oe_n_out),
        .chip_sel_out(chip_select_inputs_out),
        .we_n_out(flash_we_n_out),
        .oe_n_out(flash_oe_n_out),
        .rdata_out(cyc_rdata),
        .done_out(cyc_done)
    );

    // Register port
    always_comb begin
        rdata_d = 32'h00000000;
        if (reg_rd_in) begin
            if (reg_addr_in == `OTPWP_REG_ADDR) begin
                rdata_d = {8'h00, addr_q};
            end else if (reg_addr_in == `OTPWP_REG_DATA) begin
                rdata_d = {24'h000000, data_q};
            end else if (reg_addr_in == `OTPWP_REG_STAT) begin
                rdata_d = {23'h000000, completion_output_in, stat_q};
            end else if (reg_addr_in == `OTPWP_REG_RDAT) begin
                rdata_d = {24'h000000, sr_q};
            end else begin
                rdata_d = 32'h00000000;
            end
        end
    end

    // Sequencer
    always_comb begin
        st_d = st_q;
        ret_d = ret_q;
        addr_d = addr_q;
        data_d = data_q;
        sr_d = sr_q;
        stat_d = stat_q;
        rp_d = rp_q;
        busy_d = busy_q;
        supply_hold_d = supply_hold_q;
        tmr_d = tmr_q;
        cyc_pend_d = cyc_pend_q;
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        cyc_addr = addr_q;
        cyc_wdata = `OTPWP_CMD_RDARR;
        if (reg_wr_in && reg_addr_in == `OTPWP_REG_ADDR && st_q == OTPWP_IDLE) begin
            addr_d = reg_wdata_in[23:0];
        end
        if (reg_wr_in && reg_addr_in == `OTPWP_REG_DATA && st_q == OTPWP_IDLE) begin
            data_d = reg_wdata_in[7:0];
        end
        case (st_q)
            OTPWP_IDLE: begin
                busy_d = 1'b0;
                if (reg_wr_in && reg_addr_in == `OTPWP_REG_CTRL) begin
                    if (reg_wdata_in[`OTPWP_CTRL_RST]) begin
                        stat_d = 8'h00;
                        busy_d = 1'b1;
                        rp_d = 1'b0;
                        tmr_d = 16'(RST_CYC);
                        st_d = OTPWP_RESET;
                    end else if (reg_wdata_in[`OTPWP_CTRL_CLR]) begin
                        supply_hold_d = 1'b0;
                        stat_d = 8'h00;
                        busy_d = 1'b1;
                        ret_d = OTPWP_IDLE;
                        st_d = OTPWP_CLR;
                    end else if (reg_wdata_in[`OTPWP_CTRL_GO]) begin
                        stat_d = 8'h00;
                        if (supply_hold_q) begin
                            stat_d[`OTPWP_ST_REFUSED] = 1'b1;
                            stat_d[`OTPWP_ST_DONE] = 1'b1;
                        end else begin
                            busy_d = 1'b1;
                            ret_d = OTPWP_SETUP;
                            st_d = OTPWP_CLR;
                        end
                    end else if (reg_wdata_in[`OTPWP_CTRL_RDARR]) begin
                        busy_d = 1'b1;
                        st_d = OTPWP_RDARR;
                    end
                end
            end
            OTPWP_CLR: begin
                cyc_wdata = `OTPWP_CMD_CLRSR;
                if (!cyc_pend_q) begin
                    cyc_start = 1'b1;
                    cyc_pend_d = 1'b1;
                end else if (cyc_done) begin
                    cyc_pend_d = 1'b0;
                    st_d = (ret_q == OTPWP_IDLE) ? OTPWP_GAP : ret_q;
                    ret_d = OTPWP_IDLE;
                end
            end
            OTPWP_SETUP: begin
                cyc_wdata = `OTPWP_CMD_SETUP;
                if (!cyc_pend_q) begin
                    cyc_start = 1'b1;
                    cyc_pend_d = 1'b1;
                end else if (cyc_done) begin
                    cyc_pend_d = 1'b0;
                    st_d = OTPWP_PROG;
                end
            end
            OTPWP_PROG: begin
                cyc_wdata = data_q;
                if (!cyc_pend_q) begin
                    cyc_start = 1'b1;
                    cyc_pend_d = 1'b1;
                end else if (cyc_done) begin
                    cyc_pend_d = 1'b0;
                    tmr_d = 16'h0000;
                    st_d = OTPWP_POLL;
                end
            end
            OTPWP_POLL: begin
                cyc_write = 1'b0;
                if (!cyc_pend_q) begin
                    cyc_start = 1'b1;
                    cyc_pend_d = 1'b1;
                end else if (cyc_done) begin
                    cyc_pend_d = 1'b0;
                    sr_d = cyc_rdata;
                    tmr_d = tmr_q + 16'h0001;
                    if (cyc_rdata[`OTPWP_SR_READY]) begin
                        st_d = OTPWP_CHECK;
                    end else if (tmr_q == 16'(`OTPWP_POLL_MAX)) begin
                        stat_d[`OTPWP_ST_TIMEOUT] = 1'b1;
                        st_d = OTPWP_RDARR;
                    end
                end
            end
            OTPWP_CHECK: begin
                // Decode error flag combinations
                if (sr_q[`OTPWP_SR_SUPPLY]) begin
                    stat_d[`OTPWP_ST_LOWSUP] = 1'b1;
                    supply_hold_d = 1'b1;
                end else if (sr_q[`OTPWP_SR_PROTECT] && sr_q[`OTPWP_SR_PROG]) begin
                    stat_d[`OTPWP_ST_LOCKED] = 1'b1;
                end else if (sr_q[`OTPWP_SR_PROG]) begin
                    stat_d[`OTPWP_ST_PROGFAIL] = 1'b1;
                end
                st_d = OTPWP_RDARR;
            end
            OTPWP_RDARR: begin
                cyc_wdata = `OTPWP_CMD_RDARR;
                if (!cyc_pend_q) begin
                    cyc_start = 1'b1;
                    cyc_pend_d = 1'b1;
                end else if (cyc_done) begin
                    cyc_pend_d = 1'b0;
                    st_d = OTPWP_GAP;
                end
            end
            OTPWP_RESET: begin
                // Hold reset low, then wait a fixed RST_CYC count for recovery
                if (tmr_q != 16'h0000) begin
                    tmr_d = tmr_q - 16'h0001;
                end else begin
                    rp_d = 1'b1;
                    tmr_d = 16'(RST_CYC);
                    st_d = OTPWP_RECOVER;
                end
            end
            OTPWP_RECOVER: begin
                if (tmr_q != 16'h0000) begin
                    tmr_d = tmr_q - 16'h0001;
                end else begin
                    sr_d = 8'h00;
                    supply_hold_d = 1'b0;
                    stat_d[`OTPWP_ST_ABORT] = 1'b1;
                    st_d = OTPWP_GAP;
                end
            end
            OTPWP_GAP: begin
                stat_d[`OTPWP_ST_DONE] = 1'b1;
                busy_d = 1'b0;
                st_d = OTPWP_IDLE;
            end
            default: begin
                st_d = OTPWP_IDLE;
            end
        endcase
        stat_d[`OTPWP_ST_BUSY] = (st_d != OTPWP_IDLE) && (st_d != OTPWP_GAP);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_q <= OTPWP_IDLE;
            ret_q <= OTPWP_IDLE;
            addr_q <= 24'h000000;
            data_q <= 8'h00;
            sr_q <= 8'h00;
            stat_q <= 8'h00;
            rdata_q <= 32'h00000000;
            rp_q <= 1'b1;
            busy_q <= 1'b0;
            supply_hold_q <= 1'b0;
            tmr_q <= 16'h0000;
            cyc_pend_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ret_q <= ret_d;
            addr_q <= addr_d;
            data_q <= data_d;
            sr_q <= sr_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
            rp_q <= rp_d;
            busy_q <= busy_d;
            supply_hold_q <= supply_hold_d;
            tmr_q <= tmr_d;
            cyc_pend_q <= cyc_pend_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reset_powerdown_low_n_out = rp_q;
    assign busy_out = busy_q;
endmodule : otpwp_ctrl

// file: core/otpwp_pkg.sv
// Types for the protection register program controller
package otpwp_pkg;
    typedef enum logic [3:0] {
        OTPWP_IDLE, OTPWP_CLR, OTPWP_SETUP, OTPWP_PROG, OTPWP_POLL,
        OTPWP_CHECK, OTPWP_RDARR, OTPWP_RESET, OTPWP_RECOVER, OTPWP_GAP
    } otpwp_state_t;
endpackage : otpwp_pkg

// file: testbench/otpwp_ctrl_chk.sv
// Assertion checker for the protection register program controller
`timescale 1ns/1ps
module otpwp_ctrl_chk #(
    parameter int unsigned RST_CYC = 20
) (
    input wire logic clk_sys_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic reg_rd_in, // Read strobe
    input wire logic [31:0] reg_rdata_out, // Read data
    input wire logic flash_dq_oe_n_out, // Data drive
    input wire logic chip_select_inputs_out, // Select
    input wire logic flash_we_n_out, // Write strobe
    input wire logic flash_oe_n_out, // Output enable
    input wire logic reset_powerdown_low_n_out, // Flash reset
    input wire logic busy_out // Busy
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    logic [15:0] rp_cnt_q;
    logic [15:0] rp_cnt_d;
    always_comb begin
        rp_cnt_d = reset_powerdown_low_n_out ? 16'h0000 : rp_cnt_q + 16'h0001;
    end
    always_ff @(posedge clk_sys_in) begin
        rp_cnt_q <= rst_n_in ? rp_cnt_d : 16'h0000;
    end
    sequence s_wr_low;
        !flash_we_n_out [*8];
    endsequence
    property p_reset_idle;
        disable iff (1'b0) !rst_n_in |=> !chip_select_inputs_out && flash_we_n_out
            && flash_oe_n_out && flash_dq_oe_n_out && reset_powerdown_low_n_out && !busy_out;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle in reset");
    property p_we_sel;
        !flash_we_n_out |-> chip_select_inputs_out && !flash_dq_oe_n_out && flash_oe_n_out;
    endproperty
    a_we_sel: assert property (p_we_sel) else $error("write without select or data");
    property p_we_width;
        $fell(flash_we_n_out) |-> s_wr_low;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe too short");
    property p_drive;
        !flash_dq_oe_n_out |-> flash_oe_n_out;
    endproperty
    a_drive: assert property (p_drive) else $error("data contention");
    property p_rd_sel;
        !flash_oe_n_out |-> chip_select_inputs_out && flash_dq_oe_n_out;
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read without select");
    property p_idle_quiet;
        !busy_out |-> flash_we_n_out && flash_oe_n_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pin activity when idle");
    property p_rd_zero;
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data without strobe");
    property p_rp_pulse;
        $rose(reset_powerdown_low_n_out) |-> $past(rp_cnt_q) >= RST_CYC - 1;
    endproperty
    a_rp_pulse: assert property (p_rp_pulse) else $error("reset pulse too short");
    property p_rp_short;
        rp_cnt_q <= RST_CYC + 1;
    endproperty
    a_rp_short: assert property (p_rp_short) else $error("reset pulse too long");
endmodule : otpwp_ctrl_chk
bind otpwp_ctrl otpwp_ctrl_chk #(.RST_CYC(RST_CYC)) u_chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .flash_dq_oe_n_out(flash_dq_oe_n_out),
    .chip_select_inputs_out(chip_select_inputs_out), .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out), .busy_out(busy_out),
    .reset_powerdown_low_n_out(reset_powerdown_low_n_out));

// file: testbench/otpwp_flash_model.sv
// Behavioural model of the flash protection register side
`timescale 1ns/1ps
module otpwp_flash_model #(
    parameter int BUSY_CYC = 40,
    parameter logic [23:0] PR_LO = 24'h000080,
    parameter logic [23:0] PR_HI = 24'h000088
) (
    input wire logic clk_sys_in, // Sampling clock
    input wire logic [23:0] addr_in, // Address pins
    input wire logic [7:0] dq_in, // Data wire level
    input wire logic chip_sel_in, // Select, high
    input wire logic we_n_in, // Write strobe
    input wire logic oe_n_in, // Output enable
    input wire logic rp_n_in, // Reset/power-down
    input wire logic supply_low_in, // Program supply low
    input wire logic locked_in, // Register locked
    output logic [7:0] dq_out, // Data driven
    output logic sts_out // Completion, pulled up
);
    logic [7:0] sr_q = 8'h00;
    logic [7:0] mem_q = 8'hFF;
    logic [7:0] last_q = 8'h00;
    logic [1:0] mode_q = 2'd0;
    logic seen_q = 1'b0;
    int busy_q = 0;
    int wr_cnt = 0;
    always @(posedge clk_sys_in) begin
        if (!oe_n_in && chip_sel_in && rp_n_in) last_q <= dq_out;
        if (!rp_n_in) begin
            sr_q <= 8'h00;
            mode_q <= 2'd0;
            busy_q <= 0;
            seen_q <= 1'b0;
        end else begin
            if (busy_q > 0) busy_q <= busy_q - 1;
            seen_q <= !we_n_in && chip_sel_in;
            if (!we_n_in && chip_sel_in && !seen_q) begin
                wr_cnt <= wr_cnt + 1;
                if (mode_q == 2'd2) begin
                    mode_q <= 2'd1;
                    if (supply_low_in || sr_q[3]) begin
                        sr_q[4:3] <= 2'b11;
                    end else if (addr_in < PR_LO || addr_in > PR_HI) begin
                        sr_q[4] <= 1'b1;
                    end else if (locked_in) begin
                        sr_q[4] <= 1'b1;
                        sr_q[1] <= 1'b1;
                    end else begin
                        mem_q <= dq_in;
                        busy_q <= BUSY_CYC;
                    end
                end else begin
                    case (dq_in)
                        8'hC0: mode_q <= 2'd2;
                        8'h50: sr_q <= 8'h00;
                        8'hFF: mode_q <= 2'd0;
                        default: mode_q <= 2'd1;
                    endcase
                end
            end
        end
    end
    // Released bus shows the inverse of its last value
    assign dq_out = (!oe_n_in && chip_sel_in && rp_n_in) ?
        ((mode_q == 2'd0) ? mem_q : {busy_q == 0, sr_q[6:0]}) : ~last_q;
    assign sts_out = (busy_q == 0) || !rp_n_in;
endmodule : otpwp_flash_model

// file: testbench/test_otpwp_ctrl.sv
// Testbench for the protection register program controller
`timescale 1ns/1ps
`include "otpwp_consts.svh"
module test_otpwp_ctrl;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic supply_low = 1'b0;
    logic locked = 1'b0;
    logic [31:0] reg_rdata_out;
    logic [23:0] f_addr;
    logic [7:0] f_dq_c;
    logic [7:0] f_dq_m;
    logic [7:0] f_dq;
    logic f_oe_drv_n, f_cs, f_we_n, f_oe_n, f_rp_n, f_sts, busy_out;
    int error_cnt = 0;
    int compares = 0;
    logic [23:0] cs_addr [3] = '{24'h000200, 24'h000084, 24'h000084};
    logic [1:0] cs_pins [3] = '{2'b00, 2'b01, 2'b10};
    logic [31:0] cs_stat [3] = '{32'h10A, 32'h112, 32'h106};
    logic [31:0] cs_rdat [3] = '{32'h90, 32'h92, 32'h98};
    int w;
    assign f_dq = f_oe_drv_n ? f_dq_m : f_dq_c;
    otpwp_ctrl #(.RST_CYC(20)) u_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .flash_addr_out(f_addr), .flash_dq_out(f_dq_c),
        .flash_dq_oe_n_out(f_oe_drv_n), .flash_dq_in(f_dq), .chip_select_inputs_out(f_cs),
        .flash_we_n_out(f_we_n), .flash_oe_n_out(f_oe_n), .reset_powerdown_low_n_out(f_rp_n),
        .completion_output_in(f_sts), .busy_out(busy_out));
    otpwp_flash_model u_flash (
        .clk_sys_in(clk_sys_in), .addr_in(f_addr), .dq_in(f_dq), .chip_sel_in(f_cs),
        .we_n_in(f_we_n), .oe_n_in(f_oe_n), .rp_n_in(f_rp_n), .supply_low_in(supply_low),
        .locked_in(locked), .dq_out(f_dq_m), .sts_out(f_sts));
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out & m, exp);
        @(posedge clk_sys_in);
    endtask : rc
    task automatic run(input logic [31:0] bits);
        wr(`OTPWP_REG_CTRL, bits);
        wr(`OTPWP_REG_ADDR, 32'h000099);
        while (busy_out !== 1'b0) @(posedge clk_sys_in);
    endtask : run
    task automatic end_sim();
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rc(`OTPWP_REG_STAT, 32'h100, 32'hFFFF_FFFF);
        rc(4'hF, 32'h0, 32'hFFFF_FFFF);
        wr(`OTPWP_REG_DATA, 32'hA5);
        wr(`OTPWP_REG_ADDR, 32'h000084);
        run(32'h1);
        rc(`OTPWP_REG_ADDR, 32'h84, 32'hFFFF_FFFF);
        rc(`OTPWP_REG_STAT, 32'h102, 32'hFFFF_FFFF);
        rc(`OTPWP_REG_RDAT, 32'h80, 32'hFFFF_FFFF);
        check({24'h0, u_flash.mem_q}, 32'hA5);
        check({30'h0, u_flash.mode_q}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(`OTPWP_REG_ADDR, {8'h00, cs_addr[i]});
            supply_low <= cs_pins[i][1];
            locked <= cs_pins[i][0];
            run(32'h1);
            rc(`OTPWP_REG_STAT, cs_stat[i], 32'hFFFF_FFFF);
            rc(`OTPWP_REG_RDAT, cs_rdat[i], 32'hFFFF_FFFF);
        end
        supply_low <= 1'b0;
        w = u_flash.wr_cnt;
        run(32'h1);
        rc(`OTPWP_REG_STAT, 32'h122, 32'hFFFF_FFFF);
        check(u_flash.wr_cnt, w);
        run(32'h8);
        rc(`OTPWP_REG_STAT, 32'h182, 32'hFFFF_FFFF);
        check({24'h0, u_flash.sr_q}, 32'h0);
        check({30'h0, u_flash.mode_q}, 32'h0);
        run(32'h2);
        wr(`OTPWP_REG_DATA, 32'h3C);
        wr(`OTPWP_REG_ADDR, 32'h000084);
        run(32'h1);
        rc(`OTPWP_REG_STAT, 32'h102, 32'hFFFF_FFFF);
        check({24'h0, u_flash.mem_q}, 32'h3C);
        w = u_flash.wr_cnt;
        run(32'h4);
        rc(`OTPWP_REG_STAT, 32'h102, 32'hFFFF_FFFF);
        check(u_flash.wr_cnt, w + 1);
        check({30'h0, u_flash.mode_q}, 32'h0);
        end_sim();
    end
endmodule : test_otpwp_ctrl
